//--- logic/fih_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the fast I/O helper.
// Assumes: 20 MHz system clock.
// Notes: Register offsets are byte addresses on the plain register port.
`ifndef FIH_DEFS_SVH
`define FIH_DEFS_SVH

`define FIH_CLK_HZ 20000000
`define FIH_CLK_PERIOD_NS 50
`define FIH_MS_NS 1000000
`define FIH_MS_CYCLES (`FIH_MS_NS / `FIH_CLK_PERIOD_NS)
`define FIH_PULSE_MAX_HZ 7000
`define FIH_PER_MIN 16'((`FIH_CLK_HZ + `FIH_PULSE_MAX_HZ - 1) / `FIH_PULSE_MAX_HZ)

`define FIH_CNT_MAX 32'h05F5E0FF
`define FIH_PRESET_END 32'h0000FFFF
`define FIH_PRESETS 6'h18
`define FIH_DLY_MAX 7'h63
`define FIH_DLY_RST 7'h0A
`define FIH_MODE_RST 16'h0060
`define FIH_CTL_RST 3'h1
`define FIH_PPER_RST 32'h4000_0B2C
`define FIH_PSTEP_RST 16'h0010
`define FIH_ITIME_RST 16'h000A

`define FIH_BCD_CNT 8'h10
`define FIH_BCD_QUAD 8'h20
`define FIH_BCD_PULSE 8'h30
`define FIH_BCD_INT 8'h40
`define FIH_BCD_CATCH 8'h50

`define FIH_A_MODE 8'h00
`define FIH_A_FILT 8'h04
`define FIH_A_CTL 8'h08
`define FIH_A_COUNT 8'h0C
`define FIH_A_STAT 8'h10
`define FIH_A_PCFG 8'h14
`define FIH_A_PCNT 8'h18
`define FIH_A_PPER 8'h1C
`define FIH_A_PSTEP 8'h20
`define FIH_A_ITIME 8'h24
`define FIH_A_PRESET 8'h40

`define FIH_CTL_X2RST 0
`define FIH_CTL_CLR 1
`define FIH_CTL_ITIMER 2
`define FIH_STAT_HIT 0
`define FIH_STAT_CATCH 1
`define FIH_STAT_INT 2
`define FIH_PCFG_DIR 2
`define FIH_PCFG_GO 3
`define FIH_PCFG_STOP 4
`define FIH_PCFG_FMT 5

`endif

//--- logic/fih_fast_io_helper.sv
// Purpose: Mode-selected helper for the first four inputs and first two outputs.
// Assumes: Register port on clk_i; field pins asynchronous to clk_i.
// Notes: Only one function runs at a time; all other points bypass this block.
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "fih_defs.svh"
// Operation
// - Exactly one function runs; counting and pulse output never run together.
// - Only fast_in 0-3 and pulse_out 0-1 pass through this block.
// - Default mode 60 passes filtered inputs to the processor and outputs straight to the pins.
// - Modes 10 to 50 give the dedicated points their special function; undefined modes act as mode 60.
// - Measurement runs continuously, independent of the processor scan.
// - Mode 10 up counter, reset input, 24 presets, interrupt on preset.
// - Mode 20 decodes quadrature A and B, counting up and down.
// - Quadrature direction from phase order steps count; count can be reset.
// - Mode 30 drives pulse plus direction following a motion profile.
// - Single axis up to 7 kHz; trapezoid, registration and velocity profiles.
// - Mode 40 interrupts on an input edge or on elapsed time.
// - Mode 50 latches narrow pulses on one input for later reading.
// - Pulse catch detects pulses as short as 100 us.
// - Filters give on and off delays up to 99 ms; default mode.
// - Input functions need DC inputs, pulse output needs DC outputs.
// - Mode 60 rejects narrow pulses as a filtered discrete input.
// - Mode number is the low byte of the mode word, two BCD digits.
// - Default: inputs filtered 10 ms, outputs plain standard outputs.
// - Up counter steps once on each leading edge of fast_in_0.
module fih_fast_io_helper import fih_pkg::*; #(
	parameter int MS_CYCLES = `FIH_MS_CYCLES,
	parameter bit HAS_DC_IN = 1'b1,
	parameter bit HAS_DC_OUT = 1'b1
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [3:0] fast_in_i,
	input wire logic [1:0] proc_out_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic [3:0] proc_in_o,
	output logic pulse_out_0_o,
	output logic pulse_out_1_o,
	output logic proc_irq_o
);
	logic [3:0] sync1_q, sync2_q, prev_q, rise;
	logic [15:0] mode_q;
	logic [6:0] on_dly_q, off_dly_q;
	logic [2:0] ctl_q;
	logic [31:0] count_q, pcnt_q, pper_q, left_q, rd_val, cur_pre;
	logic [31:0] preset_q [0:23];
	logic [31:0] ms_cnt_q;
	logic [15:0] pstep_q, itime_q, itm_q, per_q, tm_q, ramp_q, half, per_lim, per_top;
	logic [16:0] per_up, lim_up;
	logic [5:0] pidx;
	logic [4:0] ptr_q;
	logic dir_q, hit_q, catch_q, intf_q, tick_q, pdir_q, fmt_q, reg_arm_q, f2_prev_q;
	logic cnt_clr, hit_set, catch_set, int_evt, pvalid, pin_range, go, halt;
	logic counting, arm_now, clr_wr;
	fih_fn_e fn;
	fih_prof_e prof_q;
	fih_pst_e pst_q;
	fih_filt_if fif();

	// Pins cross into clk_i through two flops before anything looks at them
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			sync1_q <= 4'h0;
			sync2_q <= 4'h0;
			prev_q <= 4'h0;
		end else begin
			sync1_q <= fast_in_i;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end
	// Two-flop sampling at 50 ns resolves pulses far shorter than 100 us
	assign rise = sync2_q & ~prev_q;

	always_comb begin
		case (mode_q[7:0])
			`FIH_BCD_CNT: fn = HAS_DC_IN ? FIH_FN_CNT : FIH_FN_FILT;
			`FIH_BCD_QUAD: fn = HAS_DC_IN ? FIH_FN_QUAD : FIH_FN_FILT;
			`FIH_BCD_PULSE: fn = HAS_DC_OUT ? FIH_FN_PULSE : FIH_FN_FILT;
			`FIH_BCD_INT: fn = HAS_DC_IN ? FIH_FN_INT : FIH_FN_FILT;
			`FIH_BCD_CATCH: fn = HAS_DC_IN ? FIH_FN_CATCH : FIH_FN_FILT;
			default: fn = FIH_FN_FILT;
		endcase
	end

	// Free-running millisecond tick keeps filters and timers independent of software
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			ms_cnt_q <= 32'h0;
			tick_q <= 1'b0;
		end else if (ms_cnt_q >= 32'(MS_CYCLES - 1)) begin
			ms_cnt_q <= 32'h0;
			tick_q <= 1'b1;
		end else begin
			ms_cnt_q <= ms_cnt_q + 32'h1;
			tick_q <= 1'b0;
		end
	end

	assign fif.raw = sync2_q;
	assign fif.tick = tick_q;
	assign fif.on_dly = on_dly_q;
	assign fif.off_dly = off_dly_q;
	for (genvar gi = 0; gi < 4; gi++) begin : g_filt
		fih_filter #(.IDX(gi)) u_filt (
			.clk_i(clk_i),
			.reset_i(reset_i),
			.fp(fif)
		);
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			mode_q <= `FIH_MODE_RST;
			on_dly_q <= `FIH_DLY_RST;
			off_dly_q <= `FIH_DLY_RST;
			ctl_q <= `FIH_CTL_RST;
			prof_q <= FIH_PROF_TRAP;
			pdir_q <= 1'b0;
			fmt_q <= 1'b0;
			pcnt_q <= 32'h0;
			pper_q <= `FIH_PPER_RST;
			pstep_q <= `FIH_PSTEP_RST;
			itime_q <= `FIH_ITIME_RST;
		end else if (wr_i) begin
			case (addr_i)
				`FIH_A_MODE: mode_q <= wdata_i[15:0];
				`FIH_A_FILT: begin
					on_dly_q <= (wdata_i[6:0] > `FIH_DLY_MAX) ? `FIH_DLY_MAX : wdata_i[6:0];
					off_dly_q <= (wdata_i[14:8] > `FIH_DLY_MAX) ? `FIH_DLY_MAX : wdata_i[14:8];
				end
				`FIH_A_CTL: ctl_q <= {wdata_i[`FIH_CTL_ITIMER], 1'b0, wdata_i[`FIH_CTL_X2RST]};
				`FIH_A_PCFG: begin
					prof_q <= (wdata_i[1:0] == 2'h3) ? FIH_PROF_VEL : fih_prof_e'(wdata_i[1:0]);
					pdir_q <= wdata_i[`FIH_PCFG_DIR];
					fmt_q <= wdata_i[`FIH_PCFG_FMT];
				end
				`FIH_A_PCNT: pcnt_q <= wdata_i;
				`FIH_A_PPER: pper_q <= wdata_i;
				`FIH_A_PSTEP: pstep_q <= wdata_i[15:0];
				`FIH_A_ITIME: itime_q <= wdata_i[15:0];
				default: ;
			endcase
		end
	end

	assign pidx = 6'((addr_i - `FIH_A_PRESET) >> 2);
	assign pin_range = addr_i >= `FIH_A_PRESET && addr_i[1:0] == 2'h0 && pidx < `FIH_PRESETS;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			for (int i = 0; i < 24; i++) begin
				preset_q[i] <= `FIH_PRESET_END;
			end
		end else if (wr_i && pin_range) begin
			preset_q[pidx[4:0]] <= wdata_i;
		end
	end

	// Counter and quadrature share count_q; fast_in_2 clears it when enabled
	assign cnt_clr = (wr_i && addr_i == `FIH_A_CTL && wdata_i[`FIH_CTL_CLR]) ||
		(ctl_q[`FIH_CTL_X2RST] && rise[2]);

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			count_q <= 32'h0;
			dir_q <= 1'b0;
		end else if (fn == FIH_FN_CNT || fn == FIH_FN_QUAD) begin
			if (cnt_clr) begin
				count_q <= 32'h0;
			end else if (fn == FIH_FN_CNT && rise[0]) begin
				count_q <= (count_q == `FIH_CNT_MAX) ? 32'h0 : count_q + 32'h1;
			end else if (fn == FIH_FN_QUAD && rise[0]) begin
				// A leading B is clockwise; B already high means reverse
				dir_q <= ~sync2_q[1];
				count_q <= sync2_q[1] ? count_q - 32'h1 : count_q + 32'h1;
			end
		end
	end

	// Presets must ascend; a terminator entry or the 24th slot ends the table
	assign cur_pre = (ptr_q < 5'h18) ? preset_q[ptr_q] : `FIH_PRESET_END;
	assign pvalid = cur_pre != `FIH_PRESET_END;
	assign hit_set = fn == FIH_FN_CNT && pvalid && count_q == cur_pre;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			ptr_q <= 5'h00;
		end else if (fn != FIH_FN_CNT || cnt_clr) begin
			ptr_q <= 5'h00;
		end else if (hit_set) begin
			ptr_q <= ptr_q + 5'h01;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			itm_q <= 16'h0;
		end else if (fn != FIH_FN_INT || !ctl_q[`FIH_CTL_ITIMER]) begin
			itm_q <= 16'h0;
		end else if (tick_q) begin
			itm_q <= (itm_q + 16'h1 >= itime_q) ? 16'h0 : itm_q + 16'h1;
		end
	end
	assign int_evt = fn == FIH_FN_INT && (ctl_q[`FIH_CTL_ITIMER] ?
		(tick_q && itime_q != 16'h0 && itm_q + 16'h1 >= itime_q) : rise[0]);
	assign catch_set = fn == FIH_FN_CATCH && rise[0];

	// Sticky flags: a set in the clearing cycle wins
	assign clr_wr = wr_i && addr_i == `FIH_A_STAT;
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			hit_q <= 1'b0;
			catch_q <= 1'b0;
			intf_q <= 1'b0;
		end else begin
			hit_q <= hit_set || (hit_q && !(clr_wr && wdata_i[`FIH_STAT_HIT]));
			catch_q <= catch_set || (catch_q && !(clr_wr && wdata_i[`FIH_STAT_CATCH]));
			intf_q <= int_evt || (intf_q && !(clr_wr && wdata_i[`FIH_STAT_INT]));
		end
	end

	// Pulse engine: never slower than the top period, never faster than 7 kHz
	assign per_lim = (pper_q[15:0] < `FIH_PER_MIN) ? `FIH_PER_MIN : pper_q[15:0];
	assign per_top = (pper_q[31:16] < per_lim) ? per_lim : pper_q[31:16];
	assign half = {1'b0, per_q[15:1]};
	assign per_up = {1'b0, per_q} + {1'b0, pstep_q};
	assign lim_up = {1'b0, per_lim} + {1'b0, pstep_q};
	assign go = wr_i && addr_i == `FIH_A_PCFG && wdata_i[`FIH_PCFG_GO] && fn == FIH_FN_PULSE;
	assign halt = (wr_i && addr_i == `FIH_A_PCFG && wdata_i[`FIH_PCFG_STOP]) ||
		fn != FIH_FN_PULSE;
	assign counting = prof_q == FIH_PROF_TRAP || (prof_q == FIH_PROF_REG && reg_arm_q);
	assign arm_now = prof_q == FIH_PROF_REG && !reg_arm_q && fif.filt[2] && !f2_prev_q;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			f2_prev_q <= 1'b0;
		end else begin
			f2_prev_q <= fif.filt[2];
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pst_q <= FIH_PST_IDLE;
			tm_q <= 16'h0;
			per_q <= `FIH_PER_MIN;
			left_q <= 32'h0;
			ramp_q <= 16'h0;
			reg_arm_q <= 1'b0;
		end else if (halt) begin
			pst_q <= FIH_PST_IDLE;
			tm_q <= 16'h0;
		end else begin
			case (pst_q)
				FIH_PST_IDLE: begin
					if (go && (pcnt_q != 32'h0 || prof_q == FIH_PROF_VEL)) begin
						pst_q <= FIH_PST_HIGH;
						tm_q <= 16'h0;
						per_q <= per_top;
						left_q <= pcnt_q;
						ramp_q <= 16'h0;
						reg_arm_q <= 1'b0;
					end
				end
				FIH_PST_HIGH: begin
					if (tm_q >= half - 16'h1) begin
						tm_q <= 16'h0;
						pst_q <= FIH_PST_LOW;
					end else begin
						tm_q <= tm_q + 16'h1;
					end
				end
				FIH_PST_LOW: begin
					if (tm_q >= per_q - half - 16'h1) begin
						tm_q <= 16'h0;
						pst_q <= (counting && left_q <= 32'h1) ? FIH_PST_IDLE : FIH_PST_HIGH;
						if (counting) begin
							left_q <= left_q - 32'h1;
						end
						// Trapezoid brakes once the pulses left match those spent ramping
						if (prof_q == FIH_PROF_TRAP && left_q <= {16'h0, ramp_q}) begin
							per_q <= (per_up > {1'b0, per_top}) ? per_top : per_up[15:0];
							ramp_q <= (ramp_q != 16'h0) ? ramp_q - 16'h1 : 16'h0;
						end else if ({1'b0, per_q} > lim_up) begin
							per_q <= per_q - pstep_q;
							ramp_q <= ramp_q + 16'h1;
						end else begin
							per_q <= per_lim;
						end
					end else begin
						tm_q <= tm_q + 16'h1;
					end
				end
				default: pst_q <= FIH_PST_IDLE;
			endcase
			// Registration: the filtered fast_in_2 edge starts the final count
			if (arm_now && pst_q != FIH_PST_IDLE) begin
				reg_arm_q <= 1'b1;
				left_q <= pcnt_q;
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pulse_out_0_o <= 1'b0;
			pulse_out_1_o <= 1'b0;
		end else if (fn == FIH_FN_PULSE) begin
			pulse_out_0_o <= (pst_q == FIH_PST_HIGH) && !(fmt_q && pdir_q);
			pulse_out_1_o <= fmt_q ? (pst_q == FIH_PST_HIGH) && pdir_q : pdir_q;
		end else begin
			pulse_out_0_o <= proc_out_i[0];
			pulse_out_1_o <= proc_out_i[1];
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			proc_in_o <= 4'h0;
			proc_irq_o <= 1'b0;
		end else begin
			proc_in_o <= {fif.filt[3:1], (fn == FIH_FN_CATCH) ? catch_q : fif.filt[0]};
			proc_irq_o <= hit_q || intf_q;
		end
	end

	always_comb begin
		rd_val = 32'h0;
		case (addr_i)
			`FIH_A_MODE: rd_val = {16'h0, mode_q};
			`FIH_A_FILT: rd_val = {17'h0, off_dly_q, 1'b0, on_dly_q};
			`FIH_A_CTL: rd_val = {29'h0, ctl_q};
			`FIH_A_COUNT: rd_val = count_q;
			`FIH_A_STAT: rd_val = {19'h0, ptr_q, 3'h0, pst_q != FIH_PST_IDLE, dir_q,
				intf_q, catch_q, hit_q};
			`FIH_A_PCFG: rd_val = {26'h0, fmt_q, 2'h0, pdir_q, prof_q};
			`FIH_A_PCNT: rd_val = pcnt_q;
			`FIH_A_PPER: rd_val = pper_q;
			`FIH_A_PSTEP: rd_val = {16'h0, pstep_q};
			`FIH_A_ITIME: rd_val = {16'h0, itime_q};
			default: rd_val = pin_range ? preset_q[pidx[4:0]] : 32'h0;
		endcase
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_o <= 32'h0;
		end else begin
			rdata_o <= rd_i ? rd_val : 32'h0;
		end
	end

	a_pulse_only_mode: assert property (@(posedge clk_i) disable iff (reset_i)
		(fn != FIH_FN_PULSE) |=> (pst_q == FIH_PST_IDLE))
		else $error("pulse engine active outside pulse mode");
	a_plain_outputs: assert property (@(posedge clk_i) disable iff (reset_i)
		(fn != FIH_FN_PULSE) |=> (pulse_out_0_o == $past(proc_out_i[0]) &&
		pulse_out_1_o == $past(proc_out_i[1])))
		else $error("regular outputs not passed through");
	a_count_step: assert property (@(posedge clk_i) disable iff (reset_i)
		(fn == FIH_FN_CNT && rise[0] && !cnt_clr && count_q != `FIH_CNT_MAX)
		|=> (count_q == $past(count_q) + 32'h1))
		else $error("up counter missed a leading edge");
	a_quad_reverse: assert property (@(posedge clk_i) disable iff (reset_i)
		(fn == FIH_FN_QUAD && rise[0] && !cnt_clr && sync2_q[1])
		|=> (count_q == $past(count_q) - 32'h1 && !dir_q))
		else $error("quadrature reverse step wrong");
	a_preset_irq: assert property (@(posedge clk_i) disable iff (reset_i)
		hit_set |=> hit_q ##1 proc_irq_o)
		else $error("preset match gave no interrupt");
	a_catch_seen: assert property (@(posedge clk_i) disable iff (reset_i)
		(catch_set ##1 fn == FIH_FN_CATCH) |-> catch_q ##1 proc_in_o[0])
		else $error("caught pulse not shown to processor");
	a_bad_mode: assert property (@(posedge clk_i) disable iff (reset_i)
		(mode_q[3:0] > 4'h9 || mode_q[7:4] > 4'h6) |-> (fn == FIH_FN_FILT))
		else $error("undefined mode not treated as default");
	a_rate_limit: assert property (@(posedge clk_i) disable iff (reset_i)
		(pst_q != FIH_PST_IDLE) |-> (per_q >= `FIH_PER_MIN && per_q <= per_top))
		else $error("pulse period outside limits");
	a_edge_int: assert property (@(posedge clk_i) disable iff (reset_i)
		(fn == FIH_FN_INT && !ctl_q[`FIH_CTL_ITIMER] && rise[0]) |=> intf_q ##1 proc_irq_o)
		else $error("input edge gave no interrupt");
endmodule
`default_nettype wire

//--- logic/fih_filt_if.sv
// Purpose: Carries synchronised inputs and delay settings to the filters, and filtered levels back from them.
// Assumes: One filter instance per bit of filt.
// Notes: filt is a net so that each filter drives its own bit.
`timescale 1ns/1ns
`default_nettype none
interface fih_filt_if;
	logic [3:0] raw;
	logic tick;
	logic [6:0] on_dly;
	logic [6:0] off_dly;
	wire logic [3:0] filt;
	modport top (output raw, output tick, output on_dly, output off_dly, input filt);
	modport filt_end (input raw, input tick, input on_dly, input off_dly, output filt);
endinterface
`default_nettype wire

//--- logic/fih_filter.sv
// Purpose: On-delay and off-delay filter for one dedicated input.
// Assumes: raw is already synchronised; tick is a one-cycle pulse each millisecond.
// Notes: Delay resolution is one tick, so a delay may end up to 1 ms early.
`timescale 1ns/1ns
`default_nettype none
module fih_filter import fih_pkg::*; #(
	parameter int IDX = 0
) (
	input wire logic clk_i,
	input wire logic reset_i,
	fih_filt_if.filt_end fp
);
	logic out_q;
	logic [6:0] cnt_q;
	logic [6:0] lim;

	assign lim = out_q ? fp.off_dly : fp.on_dly;
	assign fp.filt[IDX] = out_q;

	// Zero delay turns the filter into a plain pass-through
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			out_q <= 1'b0;
			cnt_q <= 7'h00;
		end else if (fp.raw[IDX] == out_q) begin
			cnt_q <= 7'h00;
		end else if (cnt_q >= lim) begin
			out_q <= fp.raw[IDX];
			cnt_q <= 7'h00;
		end else if (fp.tick) begin
			cnt_q <= cnt_q + 7'h01;
		end
	end

	a_filt_follow: assert property (@(posedge clk_i) disable iff (reset_i)
		(out_q != $past(out_q)) |-> (out_q == $past(fp.raw[IDX]) && $past(cnt_q) >= $past(lim)))
		else $error("filter output moved away from its input");
endmodule
`default_nettype wire

//--- logic/fih_pkg.sv
// Purpose: Types shared by the fast I/O helper modules.
// Assumes: Nothing beyond the defs header.
// Notes: Enumerations carry no fixed codes.
package fih_pkg;
	typedef enum logic [2:0] {
		FIH_FN_FILT, FIH_FN_CNT, FIH_FN_QUAD, FIH_FN_PULSE, FIH_FN_INT, FIH_FN_CATCH
	} fih_fn_e;
	typedef enum logic [1:0] {FIH_PROF_TRAP, FIH_PROF_REG, FIH_PROF_VEL} fih_prof_e;
	typedef enum logic [1:0] {FIH_PST_IDLE, FIH_PST_HIGH, FIH_PST_LOW} fih_pst_e;
endpackage

//--- test/fih_field_model.sv
// Purpose: Field side of the helper: sensors, encoder and a stepper drive.
// Assumes: Pins change by non-blocking assignment right after a rising clock edge.
// Notes: Pins start low, like an open sensor, and hold the last level set between commands.
`timescale 1ns/1ns
`default_nettype none
module fih_field_model (
	input wire logic clk_i,
	input wire logic step_i,
	input wire logic dir_i,
	output logic [3:0] pin_o
);
	int steps = 0;
	logic last_dir = 1'b0;
	initial pin_o = 4'h0;
	always @(posedge step_i) begin
		steps++;
	end
	// Direction read at the trailing edge, well clear of the leading one
	always @(negedge step_i) begin
		last_dir = dir_i;
	end
	task automatic clr();
		steps = 0;
	endtask
	task automatic hold(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic set(input logic [3:0] v);
		@(posedge clk_i);
		pin_o <= v;
	endtask
	task automatic pulse(input int idx, input int width);
		set(pin_o | (4'h1 << idx));
		hold(width);
		set(pin_o & ~(4'h1 << idx));
		hold(width);
	endtask
	// One encoder cycle; A leads B when moving forward
	task automatic quad(input bit fwd);
		set(fwd ? 4'h1 : 4'h2);
		hold(3);
		set(4'h3);
		hold(3);
		set(fwd ? 4'h2 : 4'h1);
		hold(3);
		set(4'h0);
		hold(3);
	endtask
endmodule
`default_nettype wire

//--- test/tb_fih_fast_io_helper.sv
// Purpose: Self-checking bench for the fast I/O helper in every mode.
// Assumes: Millisecond tick shortened to 20 cycles.
// Notes: Pulse periods stay at the 7 kHz floor, so the pulse tests dominate run time.
`timescale 1ns/1ns
`default_nettype none
`include "fih_defs.svh"
module tb_fih_fast_io_helper import fih_pkg::*;;
	localparam int MS = 20;
	localparam int MINP = (20000000 + 6999) / 7000;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [1:0] proc_out_i = 2'h0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o;
	logic [3:0] proc_in_o;
	logic [3:0] fast_in_i;
	logic pulse_out_0_o;
	logic pulse_out_1_o;
	logic proc_irq_o;
	logic [3:0] nodc_in;
	logic nodc_p0;
	logic nodc_p1;
	logic nodc_irq;
	int failures = 0;
	int checked = 0;
	int cycles = 0;
	logic [31:0] rd_q;
	fih_fast_io_helper #(.MS_CYCLES(MS)) dut (.clk_i(clk_i), .reset_i(reset_i),
		.fast_in_i(fast_in_i), .proc_out_i(proc_out_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .proc_in_o(proc_in_o),
		.pulse_out_0_o(pulse_out_0_o), .pulse_out_1_o(pulse_out_1_o), .proc_irq_o(proc_irq_o));
	fih_field_model fld (.clk_i(clk_i), .step_i(pulse_out_0_o), .dir_i(pulse_out_1_o),
		.pin_o(fast_in_i));
	// Variant without DC points: every special mode must fall back to filtering
	fih_fast_io_helper #(.MS_CYCLES(MS), .HAS_DC_IN(1'b0), .HAS_DC_OUT(1'b0)) dut_nodc (
		.clk_i(clk_i), .reset_i(reset_i), .fast_in_i(fast_in_i), .proc_out_i(proc_out_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(),
		.proc_in_o(nodc_in), .pulse_out_0_o(nodc_p0), .pulse_out_1_o(nodc_p1),
		.proc_irq_o(nodc_irq));
	initial begin
		forever #25 clk_i = ~clk_i;
	end
	task automatic stop_test();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 90000) begin
			failures++;
			stop_test();
		end
	end
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t pins %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 rd_q = rdata_o;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk_reg(rd_q, exp);
	endtask
	// Random pin and output levels must cross unchanged
	task automatic pass_io();
		logic [3:0] v;
		v = 4'($urandom);
		fld.set(v);
		proc_out_i <= v[1:0];
		fld.hold(8);
		#1 chk_pin(proc_in_o, v);
		chk_pin({2'h0, pulse_out_1_o, pulse_out_0_o}, {2'h0, v[1:0]});
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 300; i++) begin
			rd(`FIH_A_STAT);
			if (rd_q[4] === 1'b0) break;
			fld.hold(100);
		end
		chk_reg(rd_q & 32'h10, 32'h0);
	endtask
	function automatic logic [31:0] exp_filt(input int on, input int off);
		return {17'h0, 7'(off > 99 ? 99 : off), 1'b0, 7'(on > 99 ? 99 : on)};
	endfunction
	function automatic logic [31:0] exp_quad(input int f, input int r);
		return 32'(f - r);
	endfunction
	initial begin
		int f;
		int r;
		int s0;
		logic [31:0] modes [4];
		modes = '{32'h0000, 32'h0077, 32'h00A5, 32'h0015};
		void'($urandom(80));
		repeat (3) @(posedge clk_i);
		reset_i <= 1'b0;
		rdchk(`FIH_A_MODE, 32'h0060);
		rdchk(`FIH_A_FILT, exp_filt(10, 10));
		rdchk(`FIH_A_CTL, 32'h1);
		rdchk(`FIH_A_PRESET, 32'h0000FFFF);
		wr(8'h3C, 32'hFFFFFFFF);
		rdchk(8'h3C, 32'h0);
		f = $urandom_range(255, 160);
		wr(8'(f), $urandom);
		rdchk(8'(f), 32'h0);
		f = $urandom;
		wr(`FIH_A_FILT, 32'(f));
		rdchk(`FIH_A_FILT, exp_filt(f & 127, (f >> 8) & 127));
		wr(`FIH_A_FILT, 32'h7F7F);
		rdchk(`FIH_A_FILT, exp_filt(127, 127));
		$display("test reset done");
		wr(`FIH_A_FILT, 32'h0303);
		fld.pulse(1, 15);
		fld.hold(80);
		chk_pin(proc_in_o, 4'h0);
		fld.set(4'h2);
		fld.hold(100);
		chk_pin(proc_in_o, 4'h2);
		fld.set(4'h0);
		fld.hold(15);
		chk_pin(proc_in_o, 4'h2);
		fld.hold(100);
		chk_pin(proc_in_o, 4'h0);
		wr(`FIH_A_FILT, 32'h0);
		repeat (6) pass_io();
		$display("test filter done");
		wr(`FIH_A_MODE, 32'h2010);
		wr(`FIH_A_CTL, 32'h3);
		wr(`FIH_A_PRESET, 32'h3);
		wr(`FIH_A_PRESET + 8'h04, 32'h6);
		wr(`FIH_A_PRESET + 8'h08, 32'h0000FFFF);
		wr(`FIH_A_STAT, 32'h7);
		fld.set(4'h0);
		repeat (2) fld.pulse(0, 4);
		rdchk(`FIH_A_COUNT, 32'h2);
		chk_pin({3'h0, proc_irq_o}, 4'h0);
		fld.pulse(0, 4);
		rd(`FIH_A_STAT);
		chk_reg(rd_q & 32'h1F17, 32'h0101);
		chk_pin({3'h0, proc_irq_o}, 4'h1);
		chk_pin({3'h0, nodc_irq}, 4'h0);
		wr(`FIH_A_STAT, 32'h1);
		fld.hold(3);
		chk_pin({3'h0, proc_irq_o}, 4'h0);
		f = $urandom_range(2, 1);
		repeat (f) fld.pulse(0, 4);
		rdchk(`FIH_A_COUNT, 32'(3 + f));
		fld.pulse(2, 4);
		rdchk(`FIH_A_COUNT, 32'h0);
		pass_io();
		$display("test counter done");
		wr(`FIH_A_MODE, 32'h0020);
		// Pins left high by the last pass test would swallow the first A edge
		fld.set(4'h0);
		wr(`FIH_A_CTL, 32'h2);
		f = $urandom_range(6, 3);
		r = $urandom_range(2, 0);
		repeat (f) fld.quad(1);
		rd(`FIH_A_STAT);
		chk_reg(rd_q & 32'h8, 32'h8);
		repeat (r) fld.quad(0);
		rdchk(`FIH_A_COUNT, exp_quad(f, r));
		repeat (f + 2) fld.quad(0);
		rdchk(`FIH_A_COUNT, exp_quad(f, r + f + 2));
		rd(`FIH_A_STAT);
		chk_reg(rd_q & 32'h8, 32'h0);
		wr(`FIH_A_CTL, 32'h2);
		rdchk(`FIH_A_COUNT, 32'h0);
		$display("test quadrature done");
		wr(`FIH_A_MODE, 32'h0030);
		wr(`FIH_A_PPER, 32'h0);
		rdchk(`FIH_A_PPER, 32'h0);
		wr(`FIH_A_STAT, 32'h7);
		fld.clr();
		wr(`FIH_A_PCNT, 32'h3);
		wr(`FIH_A_PCFG, 32'h0C);
		rd(`FIH_A_STAT);
		chk_reg(rd_q & 32'h10, 32'h10);
		chk_pin({2'h0, nodc_p1, nodc_p0}, {2'h0, proc_out_i});
		fld.pulse(0, 4);
		wait_idle();
		chk_reg(rd_q & 32'h17, 32'h0);
		chk_reg(32'(fld.steps), 32'h3);
		chk_pin({3'h0, fld.last_dir}, 4'h1);
		fld.clr();
		wr(`FIH_A_PCFG, 32'h2A);
		rdchk(`FIH_A_PCFG, 32'h22);
		fld.hold(4 * MINP);
		wr(`FIH_A_PCFG, 32'h12);
		wait_idle();
		// Period held at the 7 kHz floor gives about five pulses here
		chk_reg(32'(fld.steps inside {[4:6]}), 32'h1);
		chk_pin({3'h0, fld.last_dir}, 4'h0);
		wr(`FIH_A_PCNT, 32'h2);
		fld.clr();
		wr(`FIH_A_PCFG, 32'h09);
		fld.hold(2 * MINP);
		s0 = fld.steps;
		fld.set(4'h4);
		wait_idle();
		fld.set(4'h0);
		chk_reg(32'(fld.steps - s0 inside {2, 3}), 32'h1);
		$display("test pulse done");
		wr(`FIH_A_MODE, 32'h0040);
		wr(`FIH_A_CTL, 32'h0);
		wr(`FIH_A_STAT, 32'h7);
		fld.pulse(0, 4);
		rd(`FIH_A_STAT);
		chk_reg(rd_q & 32'h7, 32'h4);
		chk_pin({3'h0, proc_irq_o}, 4'h1);
		wr(`FIH_A_STAT, 32'h4);
		wr(`FIH_A_CTL, 32'h4);
		wr(`FIH_A_ITIME, 32'h2);
		fld.hold(3 * MS);
		rd(`FIH_A_STAT);
		chk_reg(rd_q & 32'h4, 32'h4);
		wr(`FIH_A_ITIME, 32'h0);
		wr(`FIH_A_CTL, 32'h0);
		$display("test interrupt done");
		wr(`FIH_A_MODE, 32'h0050);
		wr(`FIH_A_STAT, 32'h7);
		fld.pulse(0, 3);
		fld.hold(30);
		chk_pin(proc_in_o & 4'h1, 4'h1);
		chk_pin(nodc_in & 4'h1, 4'h0);
		rd(`FIH_A_STAT);
		chk_reg(rd_q & 32'h2, 32'h2);
		$display("test catch done");
		foreach (modes[i]) begin
			wr(`FIH_A_MODE, modes[i]);
			pass_io();
		end
		$display("test undefined modes done");
		stop_test();
	end
endmodule
`default_nettype wire
